// ---- rtl/srac_pkg.sv ----
// Constants and state types for the SDRAM refresh and access controller
package srac_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RCNT_OFS = 8'h04;
  localparam logic [7:0] RCOR_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  // Control register fields
  localparam int CTRL_W = 21;
  localparam int MT_LSB = 0;
  localparam int BW_LSB = 3;
  localparam int BE_BIT = 5;
  localparam int MX_LSB = 6;
  localparam int MXE_BIT = 9;
  localparam int TPC_LSB = 10;
  localparam int L2_LSB = 13;
  localparam int L3_LSB = 16;
  localparam int LE_BIT = 19;
  localparam int BL4_BIT = 20;
  localparam logic [CTRL_W-1:0] CTRL_RST = 21'h0244DB;
  localparam int RC_W = 16;
  localparam logic [RC_W-1:0] RCOR_RST = 16'hFFFF;
  // Field codes
  localparam logic [2:0] MT_A3 = 3'h2;
  localparam logic [2:0] MT_BOTH = 3'h3;
  localparam logic [1:0] BW_64 = 2'h3;
  // Commands as {row strobe, column strobe, read/write}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_BANK_ACTIVATE_CMD = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE_CMD = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  // Timing
  localparam int CLK_NS = 10;
  localparam int REF_WAIT_NS = 70;
  localparam int REF_WAIT_CYC = (REF_WAIT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ROW = 9'h002,
    ST_CMD = 9'h004,
    ST_LAT = 9'h008,
    ST_DATA = 9'h010,
    ST_PCW = 9'h020,
    ST_REF = 9'h040,
    ST_SELF = 9'h080,
    ST_AWAY = 9'h100
  } srac_state_e;

  typedef struct packed {
    srac_state_e st;
    logic [CTRL_W-1:0] ctrl;
    logic [RC_W-1:0] rcnt;
    logic [RC_W-1:0] rcor;
    logic [7:0] div;
    logic pend;
    logic rq1;
    logic rq2;
    logic [31:0] rdat;
    logic wr;
    logic single;
    logic bank;
    logic [1:0] csel;
    logic [1:0] cs;
    logic [2:0] lat;
    logic [2:0] wcnt;
    logic [2:0] beat;
    logic [2:0] last;
    logic [25:0] addr;
    logic [7:0] be;
    logic [7:0] dqm;
    logic [2:0] cmd;
    logic [14:0] ap;
    logic [63:0] dq_out;
    logic [63:0] rdata;
    logic dq_oe_n;
    logic rv;
    logic ack;
    logic done;
    logic err;
    logic back_n;
    logic cke;
  } srac_q_s;
endpackage

// ---- rtl/srac_top.sv ----
// SDRAM refresh arbitration and burst access sequencer
//
// Overview of operation
// - Counter match with compare value raises refresh request and clears counter.
// - Refresh waits until the running bus cycle finishes.
// - Refresh waits through locked sequences: splits, fills, test-and-set, DMA.
// - Refresh waits while the bus is granted to another master.
// - Pending refresh requests never stack; only one refresh runs.
// - Bus acknowledge goes high as soon as a refresh is requested.
// - Type code 010 makes area 3 SDRAM; 011 makes areas 2, 3 SDRAM.
// - Burst enable is ignored; fills and copy-backs burst 32 bytes.
// - Single accesses still burst 32 bytes unless burst-4 is set on a 32-bit bus; unneeded write beats stay masked.
// - Burst-4 option on 32-bit bus: single accesses move 16 bytes.
// - Strobes, masks and enable are shared; only area selects are separate.
// - Clock enable low on frequency change, unstable clock, self-refresh.
// - Commands encoded on row, column, read/write strobes and address lines.
// - Byte-lane mask low enables a lane, high suppresses it.
// - 64-bit big-endian: lane 7 is byte 8n; little-endian reverses.
// - Row and column addresses multiplexed on pins; mux fields place only the row.
// - 64-bit, code 011: row A11-A22, column A2-A10, auto-close, bank.
// - Pins A25-A18, A1, A0 carry nothing meaningful in SDRAM cycles.
// - Burst read: activate, read with auto-close, then latch data beats.
// - Precharge wait cycles follow the access with no SDRAM command.
// - Read command to first latch equals CAS latency of the area.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module srac_top
  import srac_pkg::*;
#(
  parameter int REF_DIV = 16
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Access requests from CPU, cache and DMA
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_fill,
  input wire logic acc_area3,
  input wire logic acc_lock,
  input wire logic [25:0] acc_addr,
  input wire logic [7:0] acc_be,
  input wire logic [63:0] acc_wdata,
  output logic acc_ack,
  output logic acc_wtake,
  output logic acc_done,
  output logic acc_err,
  output logic [63:0] rd_data,
  output logic rd_valid,
  // Bus arbitration
  input wire logic bus_req_n,
  output logic bus_ack_n,
  // Clock enable control
  input wire logic freq_change,
  input wire logic clk_unstable,
  input wire logic self_ref_req,
  // SDRAM pins
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_rd_wr,
  output logic area2_select_n,
  output logic area3_select_n,
  output logic [7:0] byte_lane_mask,
  output logic sd_cke,
  output logic [14:0] sd_addr,
  input wire logic [63:0] sd_dq_in,
  output logic [63:0] sd_dq_out,
  output logic sd_dq_oe_n
);

  if (REF_DIV < 1 || REF_DIV > 256) begin : g_chk
    $error("REF_DIV must lie in 1..256");
  end

  srac_q_s q;
  srac_q_s n;
  logic tick;
  logic [1:0] sdr;
  logic wide;

  // Returns {area3 is SDRAM, area2 is SDRAM}
  function automatic logic [1:0] area_sdram(input logic [2:0] mt);
    area_sdram = {mt == MT_A3 || mt == MT_BOTH, mt == MT_BOTH};
  endfunction

  // Byte enable of byte 8n+i maps to a lane by endianness
  function automatic logic [7:0] lane_mask(input logic [7:0] be,
                                           input logic le);
    lane_mask = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      if (le) begin
        lane_mask[i] = !be[i];
      end else begin
        lane_mask[7-i] = !be[i];
      end
    end
  endfunction

  // Returns {bank bit, row pins}; narrow bus shifts one bit less
  function automatic logic [15:0] row_map(input logic [25:0] a,
                                          input logic [2:0] mx,
                                          input logic ext,
                                          input logic wd);
    logic [4:0] sh;
    logic [25:0] t;
    sh = 5'h08 + {2'h0, mx} + {4'h0, ext} - {4'h0, !wd};
    t = a >> sh;
    row_map = {t[11], t[11:0], 3'h0};
  endfunction

  // Column pins carry bank, auto-close flag, zeros and low address
  function automatic logic [14:0] col_map(input logic [25:0] a,
                                          input logic bank);
    col_map = {bank, 1'h1, 2'h0, a[10:2], 2'h0};
  endfunction

  assign tick = q.div == 8'(REF_DIV - 1);
  assign sdr = area_sdram(q.ctrl[MT_LSB +: 3]);
  // Any width code other than 64 runs the 32-bit sequence
  assign wide = q.ctrl[BW_LSB +: 2] == BW_64;

  always_comb begin
    n = q;
    n.ack = 1'h0;
    n.done = 1'h0;
    n.err = 1'h0;
    n.rv = 1'h0;
    n.rdat = 32'h0;
    n.cmd = CMD_NOP;
    n.cs = 2'h3;
    n.dq_oe_n = 1'h1;
    n.dqm = 8'hFF;
    n.rq1 = !bus_req_n;
    n.rq2 = q.rq1;
    n.div = tick ? 8'h00 : q.div + 8'h01;

    if (reg_wr) begin
      if (reg_addr == CTRL_OFS) begin
        n.ctrl = reg_wdata[CTRL_W-1:0];
      end else if (reg_addr == RCOR_OFS) begin
        n.rcor = reg_wdata[RC_W-1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == CTRL_OFS) begin
        n.rdat = {11'h0, q.ctrl};
      end else if (reg_addr == RCNT_OFS) begin
        n.rdat = {16'h0, q.rcnt};
      end else if (reg_addr == RCOR_OFS) begin
        n.rdat = {16'h0, q.rcor};
      end else if (reg_addr == STAT_OFS) begin
        n.rdat = {20'h0, q.st == ST_AWAY, q.pend, 1'h0, q.st};
      end
    end

    case (q.st)
      ST_IDLE: begin
        if (self_ref_req) begin
          n.st = ST_SELF;
          n.cmd = CMD_REF;
          n.cs = ~sdr;
        end else if (q.pend && !acc_lock) begin
          n.st = ST_REF;
          n.cmd = CMD_REF;
          n.cs = ~sdr;
          n.pend = 1'h0;
          n.ap = 15'h0000;
          n.wcnt = 3'(REF_WAIT_CYC);
        end else if (q.rq2 && !acc_lock) begin
          n.st = ST_AWAY;
        end else if (acc_req) begin
          if (acc_area3 ? sdr[1] : sdr[0]) begin
            n.st = ST_ROW;
            n.ack = 1'h1;
            n.cmd = CMD_BANK_ACTIVATE_CMD;
            n.wr = acc_write;
            n.single = !acc_fill;
            n.addr = acc_addr;
            n.be = acc_be;
            n.csel = acc_area3 ? 2'h1 : 2'h2;
            n.lat = acc_area3 ? q.ctrl[L3_LSB +: 3] : q.ctrl[L2_LSB +: 3];
            // Burst enable bit is never consulted for SDRAM
            n.last = (!wide && !(q.ctrl[BL4_BIT] && !acc_fill)) ?
                     3'h7 : 3'h3;
            {n.bank, n.ap} = row_map(acc_addr, q.ctrl[MX_LSB +: 3],
                                     q.ctrl[MXE_BIT], wide);
          end else begin
            n.err = 1'h1;
          end
        end
      end
      ST_ROW: begin
        n.st = ST_CMD;
        n.ap = col_map(q.addr, q.bank);
        if (q.wr) begin
          n.cmd = CMD_WRITE_CMD;
          n.dq_oe_n = 1'h0;
          n.dq_out = acc_wdata;
          n.dqm = q.single ? lane_mask(q.be, q.ctrl[LE_BIT]) :
                  8'h00;
          n.beat = 3'h1;
        end else begin
          n.cmd = CMD_READ;
          n.dqm = 8'h00;
          n.beat = 3'h0;
        end
      end
      ST_CMD: begin
        if (q.wr) begin
          n.st = ST_DATA;
          n.dq_oe_n = 1'h0;
          n.dq_out = acc_wdata;
          n.dqm = q.single ? 8'hFF : 8'h00;
        end else if (q.lat <= 3'h1) begin
          n.st = ST_DATA;
          n.dqm = 8'h00;
        end else begin
          n.st = ST_LAT;
          n.wcnt = q.lat - 3'h1;
          n.dqm = 8'h00;
        end
      end
      ST_LAT: begin
        n.dqm = 8'h00;
        if (q.wcnt == 3'h1) begin
          n.st = ST_DATA;
        end else begin
          n.wcnt = q.wcnt - 3'h1;
        end
      end
      ST_DATA: begin
        if (!q.wr) begin
          n.rdata = sd_dq_in;
          n.rv = !q.single || q.beat == 3'h0;
        end
        if (q.beat == q.last) begin
          if (q.ctrl[TPC_LSB +: 3] == 3'h0) begin
            n.st = ST_IDLE;
            n.done = 1'h1;
          end else begin
            n.st = ST_PCW;
            n.wcnt = q.ctrl[TPC_LSB +: 3];
          end
        end else begin
          n.beat = q.beat + 3'h1;
          if (q.wr) begin
            n.dq_oe_n = 1'h0;
            n.dq_out = acc_wdata;
            n.dqm = q.single ? 8'hFF : 8'h00;
          end else begin
            n.dqm = 8'h00;
          end
        end
      end
      ST_PCW, ST_REF: begin
        if (q.wcnt <= 3'h1) begin
          n.st = ST_IDLE;
          n.done = q.st == ST_PCW;
        end else begin
          n.wcnt = q.wcnt - 3'h1;
        end
      end
      ST_SELF: begin
        // A refresh follows at once, the counter lost track meanwhile
        if (!self_ref_req) begin
          n.st = ST_IDLE;
          n.pend = 1'h1;
        end
      end
      ST_AWAY: begin
        // The other master returns the bus by dropping its request
        if (!q.rq2) begin
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (n.st inside {ST_ROW, ST_CMD, ST_LAT, ST_DATA}) begin
      n.cs = n.csel;
    end

    // Match after the state logic, so a new request wins over the clear
    if (tick) begin
      if (q.rcnt == q.rcor) begin
        n.rcnt = '0;
        n.pend = 1'h1;
      end else begin
        n.rcnt = q.rcnt + 16'h0001;
      end
    end
    if (reg_wr && reg_addr == RCNT_OFS) begin
      n.rcnt = reg_wdata[RC_W-1:0];
    end

    n.back_n = !(n.st == ST_AWAY && !n.pend);
    n.cke = !(freq_change || clk_unstable || n.st == ST_SELF);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl <= CTRL_RST;
      q.rcor <= RCOR_RST;
      q.cmd <= CMD_NOP;
      q.cs <= 2'h3;
      q.dqm <= 8'hFF;
      q.dq_oe_n <= 1'h1;
      q.back_n <= 1'h1;
      q.cke <= 1'h1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdat;
  assign acc_ack = q.ack;
  assign acc_wtake = !n.dq_oe_n;
  assign acc_done = q.done;
  assign acc_err = q.err;
  assign rd_data = q.rdata;
  assign rd_valid = q.rv;
  assign bus_ack_n = q.back_n;
  assign {sd_ras_n, sd_cas_n, sd_rd_wr} = q.cmd;
  assign {area3_select_n, area2_select_n} = q.cs;
  assign byte_lane_mask = q.dqm;
  assign sd_cke = q.cke;
  assign sd_addr = q.ap;
  assign sd_dq_out = q.dq_out;
  assign sd_dq_oe_n = q.dq_oe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_activate;
    q.st == ST_ROW && !q.wr && q.cmd == CMD_BANK_ACTIVATE_CMD;
  endsequence
  sequence s_read_ac;
    q.st == ST_CMD && q.cmd == CMD_READ && q.ap[13];
  endsequence

  ref_match_a: assert property (
    tick && q.rcnt == q.rcor && !(reg_wr && reg_addr == RCNT_OFS)
    |=> q.pend && q.rcnt == '0)
    else $error("refresh match did not set request");
  ref_defer_a: assert property (
    $rose(q.st == ST_REF) |-> $past(q.st == ST_IDLE) && !$past(acc_lock))
    else $error("refresh started outside idle or locked");
  ref_away_a: assert property (
    q.st == ST_AWAY |=> q.st != ST_REF)
    else $error("refresh while bus granted away");
  back_neg_a: assert property (
    $rose(q.pend) |-> bus_ack_n)
    else $error("acknowledge low with refresh pending");
  cke_low_a: assert property (
    (freq_change || clk_unstable) |=> !sd_cke)
    else $error("clock enable high during clock change");
  mask_wr_a: assert property (
    q.st == ST_DATA && q.wr && q.single |-> byte_lane_mask == 8'hFF)
    else $error("unneeded write beat not masked");
  act_read_a: assert property (
    s_activate |=> s_read_ac)
    else $error("activate not followed by auto-close read");
  lat_three_a: assert property (
    s_read_ac and q.lat == 3'h3 |-> ##1 q.st == ST_LAT [*2] ##1
    q.st == ST_DATA)
    else $error("latency three not honoured");
  pcw_nop_a: assert property (
    q.st == ST_PCW |-> q.cmd == CMD_NOP && q.cs == 2'h3)
    else $error("command during precharge wait");

endmodule

// ---- test/srac_sdram_model.sv ----
// Behavioural SDRAM group that answers burst reads from the controller
`timescale 1ns/1ns
module srac_sdram_model
  import srac_pkg::*;
(
  // Command and address pins
  input wire logic clk,
  input wire logic [2:0] cmd,
  input wire logic sel_n,
  input wire logic [14:0] addr,
  input wire logic [2:0] lat,
  // Read data towards the controller
  output logic [63:0] dq
);
  logic [14:0] col = 15'h0000;
  int n = -1;
  int b;
  initial dq = 64'h0;
  // The burst runs on past the needed beats, as a real part does
  always @(posedge clk) begin
    if (sel_n === 1'b0 && cmd === CMD_READ) begin
      col = addr;
      n = 0;
    end else if (n >= 0) n++;
    b = n - (lat > 1 ? lat : 1) + 1;
    if (n >= 0 && b >= 0 && b < 8)
      dq <= {32'hDA7A0000 + 32'(b), 17'h0, col};
    else
      dq <= ~dq; // Released lines must never look like stale data
    if (b >= 7) n = -1;
  end
endmodule

// ---- test/srac_top_test.sv ----
// Self-checking bench for the SDRAM refresh and access controller
`timescale 1ns/1ns
module srac_top_test;
  import srac_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic acc_req = 1'b0, acc_write = 1'b0, acc_fill = 1'b0;
  logic acc_area3 = 1'b0, acc_lock = 1'b0;
  logic [25:0] acc_addr = 26'h0;
  logic [7:0] acc_be = 8'h00;
  logic [63:0] acc_wdata = 64'h0;
  logic bus_req_n = 1'b1;
  logic freq_change = 1'b0, clk_unstable = 1'b0, self_ref_req = 1'b0;
  logic [63:0] sd_dq_in, rd_data, sd_dq_out;
  logic [31:0] reg_rdata;
  logic acc_ack, acc_wtake, acc_done, acc_err, rd_valid, bus_ack_n;
  logic sd_ras_n, sd_cas_n, sd_rd_wr, area2_select_n, area3_select_n;
  logic [7:0] byte_lane_mask;
  logic sd_cke, sd_dq_oe_n;
  logic [14:0] sd_addr;
  logic [2:0] mlat = 3'h2;
  logic [20:0] cfg = CTRL_RST;
  logic [31:0] rs = 32'h00016688;
  logic [31:0] v;
  int mismatches = 0, check_count = 0, refs = 0;

  always #5 clk = ~clk;

  srac_top #(.REF_DIV(2)) u_srac_top (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .acc_req, .acc_write, .acc_fill, .acc_area3, .acc_lock, .acc_addr,
    .acc_be, .acc_wdata, .acc_ack, .acc_wtake, .acc_done, .acc_err,
    .rd_data, .rd_valid, .bus_req_n, .bus_ack_n, .freq_change,
    .clk_unstable, .self_ref_req, .sd_ras_n, .sd_cas_n, .sd_rd_wr,
    .area2_select_n, .area3_select_n, .byte_lane_mask, .sd_cke,
    .sd_addr, .sd_dq_in, .sd_dq_out, .sd_dq_oe_n
  );
  srac_sdram_model u_srac_sdram_model (
    .clk, .cmd({sd_ras_n, sd_cas_n, sd_rd_wr}),
    .sel_n(area2_select_n & area3_select_n), .addr(sd_addr),
    .lat(mlat), .dq(sd_dq_in)
  );

  always @(posedge clk)
    if ({sd_ras_n, sd_cas_n, sd_rd_wr} === CMD_REF) refs++;

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [63:0] beat(int k, logic [14:0] c);
    return {32'hDA7A0000 + 32'(k), 17'h0, c};
  endfunction

  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask

  task automatic setc(logic [20:0] c);
    cfg = c;
    wr(CTRL_OFS, 32'(c));
  endtask

  task automatic acc(logic w, f, a3, logic [25:0] ad, logic [7:0] be);
    int t = 0, ta = 0, nv = 0, bi = 0, tr = 0, nb, lt;
    logic tk = 1'b0;
    logic bw, mx;
    logic [2:0] c;
    logic [7:0] lm;
    logic [14:0] col;
    logic [63:0] d, e;
    logic [63:0] q[$];
    lt = a3 ? cfg[18:16] : cfg[15:13];
    lt = lt < 1 ? 1 : lt;
    bw = cfg[4:3] == BW_64;
    mx = bw && cfg[9:6] == 4'h3;
    nb = bw || (!f && cfg[BL4_BIT]) ? 4 : 8;
    for (int i = 0; i < 8; i++) lm[i] = cfg[LE_BIT] ? be[i] : be[7 - i];
    mlat <= a3 ? cfg[18:16] : cfg[15:13];
    d = {rnd(), rnd()};
    q = {d};
    {acc_write, acc_fill, acc_area3, acc_addr, acc_be} <= {w, f, a3, ad, be};
    acc_wdata <= d;
    acc_req <= 1'b1;
    do begin
      @(posedge clk);
      if (acc_ack === 1'b1) acc_req <= 1'b0;
      if (tk) begin
        d = {rnd(), rnd()};
        acc_wdata <= d;
        q.push_back(d);
      end
      #1 t++;
      tk = acc_wtake === 1'b1;
      c = {sd_ras_n, sd_cas_n, sd_rd_wr};
      if (acc_ack === 1'b1) ta = t;
      if (c === CMD_BANK_ACTIVATE_CMD) begin
        chk("sel", {area2_select_n, area3_select_n}, {a3, !a3});
        if (mx) chk("row", sd_addr[14:3], ad[22:11]);
      end else if (c === CMD_READ || c === CMD_WRITE_CMD) begin
        tr = t;
        col = sd_addr;
        chk("cmd", c, w ? CMD_WRITE_CMD : CMD_READ);
        if (!w) chk("rmask", byte_lane_mask, 8'h00);
        if (mx) chk("col", col, {ad[22], 3'h4, ad[10:2], 2'h0});
      end else if (tr > 0) chk("nop", c, CMD_NOP);
      if (sd_dq_oe_n === 1'b0) begin
        e = q.pop_front();
        if (bw && (f || bi == 0)) chk("wdat", sd_dq_out, e);
        lm = f ? 8'h00 : bi ? 8'hFF : ~lm;
        if (bw || f) chk("mask", byte_lane_mask, lm);
        lm = 8'hFF;
        bi++;
      end
      if (rd_valid === 1'b1) begin
        if (bw) chk("rdat", rd_data, beat(nv, col));
        nv++;
      end
    end while (acc_done !== 1'b1 && t < 300);
    chk("beats", w ? bi : nv, w || f ? nb : 1);
    chk("time", t - ta, 1 + nb + cfg[12:10] + (w ? 0 : lt));
    @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk("pins", {sd_cke, bus_ack_n, byte_lane_mask, sd_ras_n, sd_cas_n,
                    sd_rd_wr}, {2'h3, 8'hFF, CMD_NOP});
    @(posedge clk);
    rd(CTRL_OFS);
    chk("ctrl", v, 32'(CTRL_RST));
    rd(RCOR_OFS);
    chk("rcor", v, 32'(RCOR_RST));
    wr(STAT_OFS, 32'hFFFF);
    rd(STAT_OFS);
    chk("stat", v, 32'(ST_IDLE));
    rd(8'h10);
    chk("hole", v, 32'h0);
    repeat (10000) @(posedge clk);
    wr(RCNT_OFS, 32'h0);
    wr(RCOR_OFS, 32'h7);
    refs = 0;
    repeat (128) @(posedge clk);
    chk("dummy", refs inside {[7:8]}, 1'b1);
    wr(RCOR_OFS, 32'hFFFF);
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      setc({v[20:19], 3'(v[18:16] % 5 + 1), 3'(v[15:13] % 5 + 1),
            3'(v[12:10] % 7 + 1), 4'h3, v[5], v[4] ? 2'h3 : 2'h0,
            MT_BOTH});
      acc(v[21], v[22], v[23], 26'(rnd()), 8'(rnd()));
    end
    setc({cfg[20:3], MT_A3});
    acc_area3 <= 1'b0;
    acc_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("err", {acc_err, acc_ack}, 2'h2);
    @(posedge clk);
    acc_req <= 1'b0;
    @(posedge clk);
    acc(1'b0, 1'b1, 1'b1, 26'(rnd()), 8'hFF);
    setc({cfg[20:3], MT_BOTH});
    for (int lk = 0; lk < 2; lk++) begin
      acc_lock <= 1'(lk);
      wr(RCNT_OFS, 32'h0);
      wr(RCOR_OFS, 32'h8);
      refs = 0;
      repeat (2) acc(1'b0, 1'b1, 1'b1, 26'(rnd()), 8'hFF);
      if (lk == 1) chk("held", refs, 0);
      acc_lock <= 1'b0;
      repeat (20) @(posedge clk);
      chk("ran", refs > 0, 1'b1);
      wr(RCOR_OFS, 32'hFFFF);
    end
    wr(RCNT_OFS, 32'h0);
    bus_req_n <= 1'b0;
    for (int i = 0; i < 20 && bus_ack_n !== 1'b0; i++) @(posedge clk);
    chk("grant", bus_ack_n, 1'b0);
    wr(RCNT_OFS, 32'h0);
    wr(RCOR_OFS, 32'h2);
    for (int i = 0; i < 40 && bus_ack_n !== 1'b1; i++) @(posedge clk);
    chk("back", bus_ack_n, 1'b1);
    rd(STAT_OFS);
    chk("away", v[11:10], 2'h3);
    refs = 0;
    repeat (40) @(posedge clk);
    chk("noref", refs, 0);
    wr(RCOR_OFS, 32'hFFFF);
    wr(RCNT_OFS, 32'h0);
    refs = 0;
    bus_req_n <= 1'b1;
    repeat (40) @(posedge clk);
    chk("oneref", refs, 1);
    for (int k = 0; k < 3; k++) begin
      refs = 0;
      {freq_change, clk_unstable, self_ref_req} <= 3'h4 >> k;
      repeat (6) @(posedge clk);
      chk("cke_lo", sd_cke, 1'b0);
      {freq_change, clk_unstable, self_ref_req} <= 3'h0;
      repeat (12) @(posedge clk);
      chk("cke_hi", sd_cke, 1'b1);
      if (k == 2) chk("selfref", refs >= 2, 1'b1);
    end
    close_out();
  end
endmodule
